// file: verilog/rsi_defines.svh
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH

// ********************************************************************
// Widths
// ********************************************************************
`define RSI_IP_W        21
`define RSI_INSTR_W     16
`define RSI_PTR_W       5
`define RSI_DEPTH       32

// ********************************************************************
// Encodings
// ********************************************************************
`define RSI_OPC_DISCARD 16'h0006
`define RSI_OPC_SAVE    16'h0005
`define RSI_CALL_MASK   16'hF800
`define RSI_CALL_MATCH  16'hD800
`define RSI_OFS_MSB     10

// ********************************************************************
// Arithmetic and reset values
// ********************************************************************
`define RSI_RET_STEP    21'h000002
`define RSI_TOP_RST     21'h000000
`define RSI_PTR_RST     5'h00
`define RSI_PTR_STEP    5'h01

`endif

// file: verilog/rsi_pkg.sv
package rsi_pkg;

    // Instruction phases, Gray coded so one bit flips per clock.
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } rsi_phase_t;

    typedef enum logic [1:0] {
        CY_IDLE = 2'b00,
        CY_EXEC = 2'b01,
        CY_NOP  = 2'b11
    } rsi_cyc_t;

    typedef enum logic [1:0] {
        OP_DISCARD = 2'b00,
        OP_SAVE    = 2'b01,
        OP_CALL    = 2'b11,
        OP_NONE    = 2'b10
    } rsi_op_t;

endpackage

// file: verilog/rsi_stack_mem.sv
`timescale 1ns/10ps
`include "rsi_defines.svh"

module rsi_stack_mem
    import rsi_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   resetn_i,
    // Write port
    input  wire logic                   wr_en_i,
    input  wire logic [`RSI_PTR_W-1:0]  wr_addr_i,
    input  wire logic [`RSI_IP_W-1:0]   wr_data_i,
    // Read port
    input  wire logic [`RSI_PTR_W-1:0]  rd_addr_i,
    output logic      [`RSI_IP_W-1:0]   rd_data_o
);

    logic [`RSI_IP_W-1:0] mem_q [`RSI_DEPTH];
    logic [`RSI_IP_W-1:0] rd_data_d;
    logic [`RSI_IP_W-1:0] rd_data_q;

    always_comb begin
        rd_data_d = mem_q[rd_addr_i];
    end

    // The array has no reset; only the read register is cleared.
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        if (!resetn_i) begin
            rd_data_q <= `RSI_TOP_RST;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_o = rd_data_q;

endmodule

// file: verilog/rsi_core.sv
`timescale 1ns/10ps
`include "rsi_defines.svh"

module rsi_core
    import rsi_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     resetn_i,
    // Fetched instruction
    input  wire logic                     instr_valid_i,
    input  wire logic [`RSI_INSTR_W-1:0]  instr_word_i,
    input  wire logic [`RSI_IP_W-1:0]     instruction_pointer_i,
    // Software access to the top entry
    input  wire logic                     tos_wr_en_i,
    input  wire logic [`RSI_IP_W-1:0]     tos_wr_data_i,
    // Stack state
    output logic      [`RSI_IP_W-1:0]     stack_top_entry_o,
    output logic      [`RSI_PTR_W-1:0]    stack_depth_o,
    // Instruction pointer update
    output logic                          ip_load_o,
    output logic      [`RSI_IP_W-1:0]     ip_next_o,
    output logic                          busy_o,
    output rsi_phase_t                    phase_o
);

    localparam int IW = `RSI_IP_W;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    function automatic rsi_op_t decode_op(input logic [`RSI_INSTR_W-1:0] w);
        rsi_op_t op;
        op = OP_NONE;
        if (w == `RSI_OPC_DISCARD) begin
            op = OP_DISCARD;
        end else if (w == `RSI_OPC_SAVE) begin
            op = OP_SAVE;
        end else if ((w & `RSI_CALL_MASK) == `RSI_CALL_MATCH) begin
            op = OP_CALL;
        end
        return op;
    endfunction

    // The word offset is sign extended and doubled into a byte offset.
    function automatic logic [`RSI_IP_W-1:0] call_target(
        input logic [`RSI_IP_W-1:0]    ip,
        input logic [`RSI_INSTR_W-1:0] w
    );
        logic [`RSI_IP_W-1:0] ofs;
        ofs = {{(IW - `RSI_OFS_MSB - 2){w[`RSI_OFS_MSB]}}, w[`RSI_OFS_MSB:0], 1'b0};
        return IW'(ip + `RSI_RET_STEP + ofs);
    endfunction

    // ****************************************************************
    // Sequencing state
    // ****************************************************************
    rsi_phase_t            phase_q;
    rsi_phase_t            phase_d;
    rsi_cyc_t              cyc_q;
    rsi_cyc_t              cyc_d;
    rsi_op_t               op_q;
    rsi_op_t               op_d;
    logic [`RSI_IP_W-1:0]  ip_q;
    logic [`RSI_IP_W-1:0]  ip_d;
    logic [`RSI_INSTR_W-1:0] word_q;
    logic [`RSI_INSTR_W-1:0] word_d;
    logic [`RSI_IP_W-1:0]  next_q;
    logic [`RSI_IP_W-1:0]  next_d;
    logic                  accept;
    logic                  push_evt;
    logic                  pop_evt;
    logic                  stack_chg;
    rsi_op_t               dec_op;

    always_comb begin
        dec_op = decode_op(instr_word_i);
        accept = (phase_q == PH_Q1) && (cyc_q != CY_NOP) && instr_valid_i
                 && (dec_op != OP_NONE);
        push_evt = (cyc_q == CY_EXEC) && (phase_q == PH_Q2)
                   && ((op_q == OP_SAVE) || (op_q == OP_CALL));
        pop_evt = (cyc_q == CY_EXEC) && (phase_q == PH_Q3)
                  && (op_q == OP_DISCARD);
        stack_chg = push_evt || pop_evt;
    end

    always_comb begin
        phase_d = phase_q;
        cyc_d   = cyc_q;
        op_d    = op_q;
        ip_d    = ip_q;
        word_d  = word_q;
        next_d  = next_q;
        case (phase_q)
            PH_Q1: begin
                phase_d = PH_Q2;
                if (cyc_q != CY_NOP) begin
                    cyc_d = accept ? CY_EXEC : CY_IDLE;
                    op_d  = accept ? dec_op : OP_NONE;
                    if (accept) begin
                        ip_d   = instruction_pointer_i;
                        word_d = instr_word_i;
                    end
                end
            end
            PH_Q2: begin
                phase_d = PH_Q3;
            end
            PH_Q3: begin
                phase_d = PH_Q4;
                if ((cyc_q == CY_EXEC) && (op_q == OP_CALL)) begin
                    next_d = call_target(ip_q, word_q);
                end
            end
            PH_Q4: begin
                phase_d = PH_Q1;
                // A call spends the whole next instruction cycle idle.
                if ((cyc_q == CY_EXEC) && (op_q == OP_CALL)) begin
                    cyc_d = CY_NOP;
                    op_d  = OP_NONE;
                end else if (cyc_q == CY_NOP) begin
                    cyc_d = CY_IDLE;
                end
            end
            default: begin
                phase_d = PH_Q1;
                cyc_d   = CY_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            phase_q <= PH_Q1;
            cyc_q   <= CY_IDLE;
            op_q    <= OP_NONE;
            ip_q    <= `RSI_TOP_RST;
            word_q  <= '0;
            next_q  <= `RSI_TOP_RST;
        end else begin
            phase_q <= phase_d;
            cyc_q   <= cyc_d;
            op_q    <= op_d;
            ip_q    <= ip_d;
            word_q  <= word_d;
            next_q  <= next_d;
        end
    end

    // ****************************************************************
    // Return stack
    // ****************************************************************
    // The top entry lives in a register; deeper levels live in memory,
    // whose read port always looks one level below the top. Overflow and
    // underflow simply wrap the pointer.
    logic [`RSI_IP_W-1:0]  top_q;
    logic [`RSI_IP_W-1:0]  top_d;
    logic [`RSI_PTR_W-1:0] sp_q;
    logic [`RSI_PTR_W-1:0] sp_d;
    logic [`RSI_PTR_W-1:0] rd_addr;
    logic [`RSI_IP_W-1:0]  below;

    always_comb begin
        top_d   = top_q;
        sp_d    = sp_q;
        rd_addr = sp_q - `RSI_PTR_STEP;
        if (push_evt) begin
            top_d = IW'(ip_q + `RSI_RET_STEP);
            sp_d  = sp_q + `RSI_PTR_STEP;
        end else if (pop_evt) begin
            top_d = below;
            sp_d  = sp_q - `RSI_PTR_STEP;
        end else if (tos_wr_en_i) begin
            top_d = tos_wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            top_q <= `RSI_TOP_RST;
            sp_q  <= `RSI_PTR_RST;
        end else begin
            top_q <= top_d;
            sp_q  <= sp_d;
        end
    end

    rsi_stack_mem u_mem (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .wr_en_i   (push_evt),
        .wr_addr_i (sp_q),
        .wr_data_i (top_q),
        .rd_addr_i (rd_addr),
        .rd_data_o (below)
    );

    // No status flag is produced here; all three instructions leave them.
    assign stack_top_entry_o = top_q;
    assign stack_depth_o     = sp_q;
    assign ip_load_o         = (cyc_q == CY_EXEC) && (op_q == OP_CALL) && (phase_q == PH_Q4);
    assign ip_next_o         = next_q;
    assign busy_o            = (cyc_q == CY_NOP);
    assign phase_o           = phase_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_acc_save;
        accept && (dec_op == OP_SAVE);
    endsequence

    sequence s_acc_discard;
        accept && (dec_op == OP_DISCARD);
    endsequence

    sequence s_acc_call;
        accept && (dec_op == OP_CALL);
    endsequence

    a_discard_depth: assert property (pop_evt |=> sp_q == $past(sp_q) - `RSI_PTR_STEP)
        else $error("discard did not lower the depth by one");

    a_discard_top: assert property (pop_evt |=> top_q == $past(below))
        else $error("discard did not expose the entry below");

    a_save_value: assert property (s_acc_save |-> ##2
                                   top_q == IW'($past(instruction_pointer_i, 2) + `RSI_RET_STEP))
        else $error("save did not place pointer plus two on top");

    a_save_keep: assert property (push_evt |-> ##2 below == $past(top_q, 2))
        else $error("save lost the former top entry");

    a_save_timing: assert property (s_acc_save |=> push_evt ##1 !stack_chg[*2] ##1 !busy_o)
        else $error("save did not push in phase two only");

    a_sw_top: assert property (tos_wr_en_i && !stack_chg |=> top_q == $past(tos_wr_data_i))
        else $error("software write of the top entry was lost");

    a_call_push: assert property (s_acc_call |=> push_evt ##1
                                  top_q == IW'($past(ip_q) + `RSI_RET_STEP))
        else $error("call did not push the return address");

    a_call_target: assert property (s_acc_call |-> ##3 ip_load_o &&
                                    ip_next_o ==
                                    $past(call_target(instruction_pointer_i, instr_word_i), 3))
        else $error("call target is wrong or late");

    a_call_idle: assert property (ip_load_o |=> busy_o[*4] ##1 !busy_o)
        else $error("call second cycle is not four idle phases");

    a_discard_timing: assert property (s_acc_discard |=> !stack_chg ##1 pop_evt ##1 !stack_chg)
        else $error("discard did not pop in phase three only");

endmodule

// file: tb/rsi_fetch_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Fetch unit: offers one word per request at a Q1, follows loads
// ****************************************************************
module rsi_fetch_model
    import rsi_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    // Bench side
    input  wire logic        req_i,
    input  wire logic [15:0] word_i,
    output logic             taken_o,
    // Core side
    input  wire rsi_phase_t  phase_i,
    input  wire logic        busy_i,
    input  wire logic        ip_load_i,
    input  wire logic [20:0] ip_next_i,
    output logic             valid_o,
    output logic [15:0]      word_o,
    output logic [20:0]      ip_o
);
    always_ff @(posedge clk_sys_i) begin
        taken_o <= 1'b0;
        if (!resetn_i) begin
            valid_o <= 1'b0;
            word_o  <= 16'h0000;
            ip_o    <= 21'h000124;
        end else if (valid_o && phase_i == PH_Q1 && !busy_i) begin
            valid_o <= 1'b0;
            taken_o <= 1'b1;
            ip_o    <= ip_o + 21'h000002;
        end else if (req_i && !valid_o && phase_i == PH_Q4) begin
            valid_o <= 1'b1;
            word_o  <= word_i;
        end else if (!valid_o) begin
            // An idle bus shows a changing word so a stale sample is caught.
            word_o  <= ~word_o;
        end
        if (resetn_i && ip_load_i) begin
            ip_o <= ip_next_i;
        end
    end
endmodule

// file: tb/return_stack_instructions_tb.sv
`timescale 1ns/10ps

module return_stack_instructions_tb
    import rsi_pkg::*;
;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic        clk_sys_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        req       = 1'b0;
    logic        tos_en    = 1'b0;
    logic [15:0] word      = 16'h0000;
    logic [20:0] tos_data  = 21'h000000;
    logic        valid, taken, ip_load, busy;
    logic [15:0] instr;
    logic [20:0] ip, top, ip_next;
    logic [4:0]  depth;
    rsi_phase_t  phase;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [20:0] stk[$];
    logic [20:0] top_e = 21'h000000;
    logic [20:0] ip_e  = 21'h000124;

    initial forever #12.5 clk_sys_i = ~clk_sys_i;

    rsi_core i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .instr_valid_i(valid),
        .instr_word_i(instr), .instruction_pointer_i(ip), .tos_wr_en_i(tos_en),
        .tos_wr_data_i(tos_data), .stack_top_entry_o(top), .stack_depth_o(depth),
        .ip_load_o(ip_load), .ip_next_o(ip_next), .busy_o(busy), .phase_o(phase));

    rsi_fetch_model i_fetch (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req),
        .word_i(word), .taken_o(taken), .phase_i(phase), .busy_i(busy),
        .ip_load_i(ip_load), .ip_next_i(ip_next), .valid_o(valid), .word_o(instr),
        .ip_o(ip));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [20:0] tgt(input logic [20:0] a, input logic [15:0] w);
        return a + 21'h000002 + {{9{w[10]}}, w[10:0], 1'b0};
    endfunction

    task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Counts: %0d compared, %0d unexpected", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk_sys_i);
        #1;
    endtask

    task automatic tos_w(input logic [20:0] d);
        @(posedge clk_sys_i);
        tos_en   <= 1'b1;
        tos_data <= d;
        @(posedge clk_sys_i);
        tos_en   <= 1'b0;
        tos_data <= ~d;
        #1;
        top_e = d;
        chk(top, top_e);
    endtask

    task automatic run(input logic [15:0] w);
        int          i;
        logic [20:0] cur;
        logic        call;
        cur  = ip_e;
        call = (w[15:11] == 5'b11011);
        @(posedge clk_sys_i);
        req  <= 1'b1;
        word <= w;
        for (i = 0; i < 40; i++) begin
            step();
            if (taken === 1'b1) break;
        end
        if (i == 40) begin
            bad_count++;
            $display("unexpected at %0t: instruction never taken", $time);
            wrap_up();
        end
        ip_e = cur + 21'h000002;
        chk(top, top_e);
        // A held request makes the fetch offer a save during the dead cycle.
        @(posedge clk_sys_i);
        if (call) word <= 16'h0005;
        else req <= 1'b0;
        #1;
        if (w == 16'h0005 || call) begin
            stk.push_back(top_e);
            top_e = cur + 21'h000002;
        end
        chk(top, top_e);
        step();
        if (w == 16'h0006) top_e = stk.pop_back();
        chk(top, top_e);
        chk(depth, 21'(stk.size()));
        if (call) begin
            chk(ip_load, 21'h000001);
            chk(ip_next, tgt(cur, w));
            ip_e = tgt(cur, w);
            repeat (4) begin
                step();
                chk(busy, 21'h000001);
                chk(ip_load, 21'h000000);
                chk(taken, 21'h000000);
                chk(top, top_e);
            end
            @(posedge clk_sys_i);
            req <= 1'b0;
            #1;
            chk(busy, 21'h000000);
            step();
            chk(taken, 21'h000001);
            step();
            stk.push_back(top_e);
            top_e = ip_e + 21'h000002;
            ip_e  = top_e;
            chk(top, top_e);
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int r;
        void'($urandom(32'h61deafeb));
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        #1;
        chk(top, 21'h000000);
        chk(depth, 21'h000000);
        chk(phase, PH_Q1);
        $display("Test reset done");
        tos_w(21'h00345A);
        run(16'h0005);
        run(16'h0006);
        $display("Test save and discard done");
        run(16'hDC00);
        run(16'hDBFF);
        run(16'h0000);
        $display("Test call bounds done");
        repeat (80) begin
            r = $urandom % 8;
            if (r == 0) tos_w(21'($urandom));
            if ((r < 3 && stk.size() > 0) || stk.size() > 24) run(16'h0006);
            else if (r < 5) run(16'h0005);
            else if (r < 7) run(16'hD800 | 16'($urandom & 32'h07FF));
            else run(16'($urandom % 4));
        end
        $display("Test random done");
        wrap_up();
    end
endmodule
